// ---- design/cfm_monitor.sv ----
// Purpose: contactor feedback monitor guarding one safety output
// Assumes: feedback_loop_i high means all contactors de-energised
// Notes: fault clears only when output_cmd_i is withdrawn
`timescale 1ns/1ps

module cfm_monitor
	import cfm_pkg::*;
#(
	parameter longint unsigned STUCK_CYCLES = CFM_STUCK_CYCLES,
	parameter longint unsigned FLASH_CYCLES = CFM_FLASH_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic output_cmd_i,
	input wire logic feedback_loop_i,
	output logic safety_out_o,
	output logic output_fault_lamp_o,
	output logic fault_o,
	output cfm_err_rec_t err_push_o
);

	// ****************************************
	// feedback input
	// ****************************************
	logic loop_sync;
	logic loop_released;

	cfm_sync u_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.d_i(feedback_loop_i),
		.q_o(loop_sync)
	);

	assign loop_released = loop_sync;

	// ****************************************
	// state machine
	// ****************************************
	cfm_state_t state_q;
	logic [CFM_CNT_W-1:0] timer_q;
	logic timer_done;
	logic open_at_on;
	logic stuck;

	assign timer_done = (timer_q >= CFM_CNT_W'(STUCK_CYCLES - 64'h1));
	// with a closed command the loop must have been released to switch on
	assign open_at_on = (state_q == CFM_ARMED) && !loop_released;
	assign stuck = (state_q == CFM_ON) && loop_released
		&& timer_done;

	// armed checks for a released loop before driving the output, an open loop goes to fault
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_q <= CFM_IDLE;
		end else begin
			unique case (state_q)
				CFM_IDLE: begin
					if (output_cmd_i) begin
						state_q <= CFM_ARMED;
					end
				end
				CFM_ARMED: begin
					if (!output_cmd_i) begin
						state_q <= CFM_IDLE;
					end else if (open_at_on) begin
						state_q <= CFM_FAULT;
					end else begin
						state_q <= CFM_ON;
					end
				end
				CFM_ON: begin
					if (!output_cmd_i) begin
						state_q <= CFM_IDLE;
					end else if (stuck) begin
						state_q <= CFM_FAULT;
					end
				end
				CFM_FAULT: begin
					if (!output_cmd_i) begin
						state_q <= CFM_IDLE;
					end
				end
			endcase
		end
	end

	// window timer restarts at each switch-on edge, saturates after
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			timer_q <= '0;
		end else if (state_q != CFM_ON) begin
			timer_q <= '0;
		end else if (!timer_done) begin
			timer_q <= timer_q + CFM_CNT_W'(1);
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// output driven in on state or from armed with a released loop, dropped the cycle a fault hits
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			safety_out_o <= CFM_OUT_RST;
		end else begin
			safety_out_o <= output_cmd_i && !stuck
				&& ((state_q == CFM_ON)
				|| (state_q == CFM_ARMED && loop_released));
		end
	end

	// one-cycle error record pulse on fault entry
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			err_push_o <= '0;
		end else begin
			err_push_o <= '0;
			if (output_cmd_i && open_at_on) begin
				err_push_o <= '{valid: 1'b1,
					code: CFM_ERR_OPEN_AT_ON};
			end else if (output_cmd_i && stuck) begin
				err_push_o <= '{valid: 1'b1,
					code: CFM_ERR_STUCK_CLOSED};
			end
		end
	end

	// fault level mirrors the fault state
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			fault_o <= 1'b0;
		end else begin
			fault_o <= (state_q == CFM_FAULT) ? output_cmd_i
				: (output_cmd_i && (open_at_on || stuck));
		end
	end

	// ****************************************
	// lamp flasher
	// ****************************************
	logic [CFM_CNT_W-1:0] flash_q;
	logic flash_tick;

	assign flash_tick = (flash_q == CFM_CNT_W'(FLASH_CYCLES - 64'h1));

	// divider runs free; lamp phase only matters during a fault
	always_ff @(posedge clk_i) begin
		if (reset_i || flash_tick) begin
			flash_q <= '0;
		end else begin
			flash_q <= flash_q + CFM_CNT_W'(1);
		end
	end

	// lamp starts lit on fault entry, then toggles each tick
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			output_fault_lamp_o <= CFM_LAMP_RST;
		end else if (state_q != CFM_FAULT || !output_cmd_i) begin
			output_fault_lamp_o <= output_cmd_i
				&& (open_at_on || stuck);
		end else if (flash_tick) begin
			output_fault_lamp_o <= !output_fault_lamp_o;
		end
	end

endmodule : cfm_monitor

// ---- design/cfm_pkg.sv ----
// Purpose: shared constants and types for the contactor feedback monitor
// Assumes: 100 MHz system clock
// Notes: times are kept in their own unit, cycle counts derived here
package cfm_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CFM_CLK_HZ = 100_000_000;
	localparam int unsigned CFM_STUCK_TIME_S = 3;
	localparam longint unsigned CFM_STUCK_CYCLES =
		longint'(CFM_STUCK_TIME_S) * longint'(CFM_CLK_HZ);
	localparam int unsigned CFM_CNT_W = 32;
	// lamp toggles every 250 ms, about 2 Hz flash
	localparam int unsigned CFM_FLASH_TIME_MS = 250;
	localparam longint unsigned CFM_FLASH_CYCLES =
		longint'(CFM_FLASH_TIME_MS) * longint'(CFM_CLK_HZ) / 64'h3E8;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic CFM_OUT_RST = 1'b0;
	localparam logic CFM_LAMP_RST = 1'b0;

	// ****************************************
	// types
	// ****************************************
	// gray along idle -> armed -> on -> fault
	typedef enum logic [1:0] {
		CFM_IDLE = 2'b00,
		CFM_ARMED = 2'b01,
		CFM_ON = 2'b11,
		CFM_FAULT = 2'b10
	} cfm_state_t;

	typedef enum logic [1:0] {
		CFM_ERR_NONE = 2'h0,
		CFM_ERR_OPEN_AT_ON = 2'h1,
		CFM_ERR_STUCK_CLOSED = 2'h2
	} cfm_err_t;

	// error record pushed to the external stack
	typedef struct packed {
		logic valid;
		cfm_err_t code;
	} cfm_err_rec_t;

endpackage : cfm_pkg

// ---- design/cfm_sync.sv ----
// Purpose: two-stage synchroniser for the feedback loop level
// Assumes: single clock, synchronous active high reset
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module cfm_sync (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic d_i,
	output logic q_o
);

	logic meta_q;

	// reset to loop-open-safe level: high means de-energised
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta_q <= 1'b1;
			q_o <= 1'b1;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end

endmodule : cfm_sync

// ---- dv/cfm_contactor_model.sv ----
// Purpose: contactors with series feedback contacts
// Assumes: armature lags coil by three cycles
// Notes: mode 1 never pulls in, mode 2 welded
`timescale 1ns/1ps
module cfm_contactor_model (
	input wire logic clk_i,
	input wire logic coil_i,
	input wire logic [1:0] mode_i,
	output logic loop_o
);
	logic [2:0] pull_q = 3'h0;
	// armature lags the coil
	always_ff @(posedge clk_i) begin
		pull_q <= {pull_q[1:0], coil_i};
	end
	// loop high only while every contact is released
	assign loop_o = mode_i == 2'h1 || (mode_i == 2'h0 && !pull_q[2]);
endmodule : cfm_contactor_model

// ---- dv/cfm_monitor_props.sv ----
// Purpose: port checks on cfm_monitor
// Assumes: stuck count set by parameter
// Notes: bound after the module
`timescale 1ns/1ps
module cfm_monitor_props
	import cfm_pkg::*;
#(parameter longint unsigned STUCK_CYCLES = 50) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic output_cmd_i,
	input wire logic feedback_loop_i,
	input wire logic safety_out_o,
	input wire logic output_fault_lamp_o,
	input wire logic fault_o,
	input wire cfm_err_rec_t err_push_o
);
	// consecutive cycles with output on and loop still released;
	// a counter, since the real window is far beyond any delay range
	longint unsigned tmo_q;
	always_ff @(posedge clk_i) begin
		if (reset_i || !(safety_out_o && feedback_loop_i)) begin
			tmo_q <= 64'h0;
		end else begin
			tmo_q <= tmo_q + 64'h1;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// ****
	// fault reaction
	// ****
	property p_kill; $rose(fault_o) |-> !safety_out_o && err_push_o.valid;
	endproperty
	a_kill: assert property (p_kill) else $error("kill");
	property p_one; err_push_o.valid |=> !err_push_o.valid; endproperty
	a_one: assert property (p_one) else $error("push");
	property p_lamp; !fault_o |-> !output_fault_lamp_o; endproperty
	a_lamp: assert property (p_lamp) else $error("lamp");
	property p_hold; fault_o && output_cmd_i |=> fault_o; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_clr; fault_o && !output_cmd_i |=> !fault_o; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_ref; $rose(safety_out_o) |-> $past(feedback_loop_i, 3);
	endproperty
	a_ref: assert property (p_ref) else $error("refuse");
	// margin of 8 covers sync and state latency
	property p_tmo; tmo_q <= STUCK_CYCLES + 64'h8; endproperty
	a_tmo: assert property (p_tmo) else $error("stuck");
	property p_code; $rose(fault_o) && !$past(safety_out_o) |->
		err_push_o.code == CFM_ERR_OPEN_AT_ON; endproperty
	a_code: assert property (p_code) else $error("code");
	c_fault: cover property ($rose(fault_o));
	c_on: cover property ($rose(safety_out_o));
	c_clr: cover property ($fell(fault_o));
endmodule : cfm_monitor_props
bind cfm_monitor cfm_monitor_props #(.STUCK_CYCLES(STUCK_CYCLES)) u_props (
	.clk_i(clk_i),
	.reset_i(reset_i),
	.output_cmd_i(output_cmd_i),
	.feedback_loop_i(feedback_loop_i),
	.safety_out_o(safety_out_o),
	.output_fault_lamp_o(output_fault_lamp_o),
	.fault_o(fault_o),
	.err_push_o(err_push_o)
);

// ---- dv/test_contactor_feedback_monitor.sv ----
// Purpose: scenario bench for cfm_monitor
// Assumes: short counts via parameters
// Notes: contactor model drives the loop
`timescale 1ns/1ps
module test_contactor_feedback_monitor;
	import cfm_pkg::*;
	logic clk_i = 1'h0, reset_i = 1'h1, output_cmd_i = 1'h0;
	logic feedback_loop_i, safety_out_o, output_fault_lamp_o, fault_o;
	cfm_err_rec_t err_push_o;
	logic [1:0] mode = 2'h0;
	logic [2:0] code_q = 3'h0;
	int miscompares = 0, checks_done = 0, flips = 0;
	cfm_monitor #(.STUCK_CYCLES(50), .FLASH_CYCLES(4)) dut (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.output_cmd_i(output_cmd_i),
		.feedback_loop_i(feedback_loop_i),
		.safety_out_o(safety_out_o),
		.output_fault_lamp_o(output_fault_lamp_o),
		.fault_o(fault_o),
		.err_push_o(err_push_o)
	);
	cfm_contactor_model model (.clk_i(clk_i), .coil_i(safety_out_o),
		.mode_i(mode), .loop_o(feedback_loop_i));
	// clock and error capture, push is one cycle only
	initial forever #5 clk_i = !clk_i;
	always @(posedge clk_i) if (err_push_o.valid) code_q <= err_push_o.code;
	always @(output_fault_lamp_o) flips++;
	task automatic chk(string what, logic [2:0] seen, logic [2:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic step(int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step
	// raise command with loop state set by mode
	task automatic arm(logic [1:0] m);
		mode = m;
		step(6);
		output_cmd_i = 1'h1;
		step(3);
	endtask : arm
	task automatic t_normal;
		arm(2'h0);
		chk("on", safety_out_o, 3'h1);
		step(60);
		chk("held", {safety_out_o, fault_o}, 3'h2);
		output_cmd_i = 1'h0;
		step(2);
		chk("off", safety_out_o, 3'h0);
	endtask : t_normal
	task automatic t_open;
		arm(2'h2);
		chk("refuse", {safety_out_o, fault_o}, 3'h1);
		chk("code", code_q, CFM_ERR_OPEN_AT_ON);
		flips = 0;
		step(12);
		// 12 cycles at a toggle every 4 cycles give exactly 3 flips
		chk("flash", 3'(flips), 3'h3);
		chk("kept", fault_o, 3'h1);
		output_cmd_i = 1'h0;
		step(2);
		chk("clear", {fault_o, output_fault_lamp_o}, 3'h0);
	endtask : t_open
	task automatic t_stuck;
		arm(2'h1);
		chk("on", safety_out_o, 3'h1);
		step(40);
		chk("early", fault_o, 3'h0);
		step(20);
		chk("stuck", {safety_out_o, fault_o}, 3'h1);
		chk("code", code_q, CFM_ERR_STUCK_CLOSED);
		output_cmd_i = 1'h0;
	endtask : t_stuck
	task automatic complete_run;
		if (miscompares == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// main sequence after reset
	initial begin
		step(20);
		reset_i = 1'h0;
		t_normal;
		t_open;
		t_stuck;
		complete_run;
	end
	// watchdog, run needs about 185 cycles
	initial begin
		#20000;
		miscompares++;
		complete_run;
	end
endmodule : test_contactor_feedback_monitor
